// ### rtl/ssbwl_pkg.sv
// constants, types and helpers shared by both ends of the memory link
package ssbwl_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int DEPTH = 16384;
  localparam int LOW_LANE = 0;
  localparam int HIGH_LANE = 1;

  // ----------------------------------------------------------------
  // timing, in ns as printed, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ACCESS_NS = 12;
  localparam int T_HOLD_NS = 5;
  localparam int T_DRIVE_AFTER_NS = 8;
  localparam int T_RELEASE_NS = 10;
  localparam int T_OE_RELEASE_NS = 5;
  localparam int T_DATA_TO_LATCH_NS = 2;

  // longest time: round down, never below one cycle
  function automatic int cyc_max(input int ns);
    cyc_max = (ns / CLK_PERIOD_NS < 1) ? 1 : ns / CLK_PERIOD_NS;
  endfunction

  // least time: round up, never below one cycle
  function automatic int cyc_min(input int ns);
    cyc_min = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc_min < 1) cyc_min = 1;
  endfunction

  localparam int ACCESS_CYC = cyc_max(T_ACCESS_NS);
  localparam int HOLD_CYC = cyc_min(T_HOLD_NS);
  localparam int DRIVE_AFTER_CYC = cyc_min(T_DRIVE_AFTER_NS);
  localparam int RELEASE_CYC = cyc_max(T_RELEASE_NS);
  localparam int DATA_TO_LATCH_CYC = cyc_min(T_DATA_TO_LATCH_NS);

  // ----------------------------------------------------------------
  // idle pin levels
  // ----------------------------------------------------------------
  localparam logic [LANES-1:0] STROBES_IDLE = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  typedef logic [ADDR_W-1:0] ssbwl_addr_t;
  typedef logic [DATA_W-1:0] ssbwl_data_t;

  // both enables must agree for a selected cycle
  function automatic logic ssbwl_selected(input logic hi,
                                          input logic lo_n);
    ssbwl_selected = hi & ~lo_n;
  endfunction

endpackage

// ### rtl/ssbwl_link_if.sv
// pin bundle between the memory device and its controller
`timescale 1ns/1ps
`default_nettype none
interface ssbwl_link_if;
  import ssbwl_pkg::*;

  logic [ADDR_W-1:0] word_address;
  logic chip_select_hi;
  logic chip_select_lo_n;
  logic sync_write_n;
  logic low_byte_strobe_n;
  logic high_byte_strobe_n;
  logic out_en_n;
  logic data_in_latch_ctl;
  logic [DATA_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DATA_W-1:0] data_bus;

  // resolved common data bus; with nobody driving it shows the
  // complement of the controller's last word, so a sample taken
  // after release reads wrong instead of passing by luck
  assign data_bus = dev_dq_oe ? dev_dq :
                    (ctl_dq_oe ? ctl_dq : ~ctl_dq);

  modport dev (
    input word_address, chip_select_hi, chip_select_lo_n,
    input sync_write_n, low_byte_strobe_n, high_byte_strobe_n,
    input out_en_n, data_in_latch_ctl, data_bus,
    output dev_dq, dev_dq_oe
  );

  modport ctl (
    output word_address, chip_select_hi, chip_select_lo_n,
    output sync_write_n, low_byte_strobe_n, high_byte_strobe_n,
    output out_en_n, data_in_latch_ctl, ctl_dq, ctl_dq_oe,
    input data_bus
  );

endinterface // ssbwl_link_if
`default_nettype wire

// ### rtl/ssbwl_device.sv
// synchronous 16k x 16 static memory with data-in latch
`timescale 1ns/1ps
`default_nettype none
module ssbwl_device
  import ssbwl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  ssbwl_link_if.dev link,
  output logic busy_reading_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // registered cycle controls, data-in latch and output stage
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic sel;
    logic wr_n;
    logic [DATA_W-1:0] latch;
    logic [DATA_W-1:0] dout;
    logic drive;
  } ssbwl_dev_s;

  localparam ssbwl_dev_s DEV_RST = '{
    addr: ADDR_ZERO,
    sel: 1'b0,
    wr_n: 1'b1,
    latch: DATA_ZERO,
    dout: DATA_ZERO,
    drive: 1'b0
  };

  ssbwl_dev_s st_reg;
  ssbwl_dev_s st_next;

  // array storage, addressed by the registered word address
  logic [DATA_W-1:0] mem_reg [DEPTH];

  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  logic rd_cycle;
  logic wr_cycle;
  logic [DATA_W-1:0] wdata;
  logic [LANES-1:0] lane_strobe_n;

  // a cycle is decided by what was registered at the last rise
  assign rd_cycle = st_reg.sel & st_reg.wr_n;
  assign wr_cycle = st_reg.sel & ~st_reg.wr_n;

  // high latch control passes the pins straight through,
  // low hands over the word caught when it fell
  assign wdata = link.data_in_latch_ctl ? link.data_bus
                                        : st_reg.latch;

  // strobes are sampled at the closing rise, i.e. their level
  // through the clock-low half decides the lane
  assign lane_strobe_n[LOW_LANE] = link.low_byte_strobe_n;
  assign lane_strobe_n[HIGH_LANE] = link.high_byte_strobe_n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one pass computes every registered field
  always_comb begin
    st_next = st_reg;
    // synchronous inputs captured on every rising edge
    st_next.addr = link.word_address;
    st_next.sel = ssbwl_selected(link.chip_select_hi,
                                 link.chip_select_lo_n);
    st_next.wr_n = link.sync_write_n;
    // data latch follows while open, freezes once closed
    if (link.data_in_latch_ctl) begin
      st_next.latch = link.data_bus;
    end
    // output stage: load on a selected read, otherwise keep
    // the old word so the pins hold until replaced
    if (rd_cycle) begin
      st_next.dout = mem_reg[st_reg.addr];
      st_next.drive = 1'b1;
    end else begin
      // deselect or write registered: release the bus
      st_next.drive = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset clears every registered field but wr_n, which goes high, latch and output word included; pins start released
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg <= DEV_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // array write
  // ----------------------------------------------------------------
  // per-lane commit; a lane whose strobe went back high by clock
  // low is left untouched, which is how late writes are aborted.
  // the array has no reset: contents are undefined until written
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (!srst_i && wr_cycle && !lane_strobe_n[i]) begin
        mem_reg[st_reg.addr][i*BYTE_W +: BYTE_W] <=
          wdata[i*BYTE_W +: BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // output enable gates the drive without waiting for a clock,
  // so a high level releases the pins in the same cycle
  assign link.dev_dq = st_reg.dout;
  assign link.dev_dq_oe = st_reg.drive & ~link.out_en_n;

  // status for the user: the output stage has just loaded a read word and is set to drive it
  assign busy_reading_o = st_reg.drive;

endmodule // ssbwl_device
`default_nettype wire

// ### rtl/ssbwl_ctrl.sv
// sequential bus controller driving the memory link, one request at a time
`timescale 1ns/1ps
`default_nettype none
module ssbwl_ctrl
  import ssbwl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic req_latched_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [LANES-1:0] req_be_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  ssbwl_link_if.ctl link
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_CMD, ST_WRITE, ST_RWAIT, ST_RCAP
  } ssbwl_ctl_e;

  typedef struct packed {
    ssbwl_ctl_e state;
    logic write;
    logic latched;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] addr;
    logic cs;
    logic sw_n;
    logic [LANES-1:0] strobe_n;
    logic oe_n;
    logic dl;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic [DATA_W-1:0] rdata;
    logic rsp;
  } ssbwl_ctl_s;

  localparam ssbwl_ctl_s CTL_RST = '{
    state: ST_IDLE, write: 1'b0, latched: 1'b0,
    be: 2'h0, wdata: DATA_ZERO, addr: ADDR_ZERO,
    cs: 1'b0, sw_n: 1'b1, strobe_n: STROBES_IDLE,
    oe_n: 1'b1, dl: 1'b1, dq: DATA_ZERO, dq_oe: 1'b0,
    rdata: DATA_ZERO, rsp: 1'b0
  };

  ssbwl_ctl_s st_reg;
  ssbwl_ctl_s st_next;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // every pin is a flop, so each level lands on a clock edge
  // and holds steady around the device's sampling edge
  always_comb begin
    st_next = st_reg;
    st_next.rsp = 1'b0;
    case (st_reg.state)
      ST_IDLE: begin
        if (req_valid_i) begin
          st_next.write = req_write_i;
          st_next.latched = req_latched_i;
          st_next.be = req_be_i;
          st_next.wdata = req_wdata_i;
          if (req_write_i && req_latched_i) begin
            // bus is free here: reads finish with it released
            st_next.state = ST_LOAD;
            st_next.dq = req_wdata_i;
            st_next.dq_oe = 1'b1;
            st_next.dl = 1'b1;
          end else begin
            st_next.state = ST_CMD;
            st_next.addr = req_addr_i;
            st_next.cs = 1'b1;
            st_next.sw_n = ~req_write_i;
          end
        end
      end
      ST_LOAD: begin
        // data stood a full cycle before the latch closes
        st_next.state = ST_CMD;
        st_next.dl = 1'b0;
        st_next.dq_oe = 1'b0;
        st_next.addr = req_addr_i;
        st_next.cs = 1'b1;
        st_next.sw_n = 1'b0;
      end
      ST_CMD: begin
        // one registered cycle per request, then deselect
        st_next.cs = 1'b0;
        st_next.sw_n = 1'b1;
        if (st_reg.write) begin
          st_next.state = ST_WRITE;
          st_next.strobe_n = ~st_reg.be;
          if (!st_reg.latched) begin
            st_next.dq = st_reg.wdata;
            st_next.dq_oe = 1'b1;
            st_next.dl = 1'b1;
          end
        end else begin
          st_next.state = ST_RWAIT;
          st_next.oe_n = 1'b0;
        end
      end
      ST_WRITE: begin
        st_next.state = ST_IDLE;
        st_next.strobe_n = STROBES_IDLE;
        st_next.dq_oe = 1'b0;
        st_next.dl = 1'b1;
      end
      ST_RWAIT: begin
        st_next.state = ST_RCAP;
      end
      ST_RCAP: begin
        st_next.state = ST_IDLE;
        st_next.rdata = link.data_bus;
        st_next.rsp = 1'b1;
        st_next.oe_n = 1'b1;
      end
      default: begin
        st_next = CTL_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_reg <= CTL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign req_ready_o = (st_reg.state == ST_IDLE);
  assign rsp_valid_o = st_reg.rsp;
  assign rsp_rdata_o = st_reg.rdata;
  assign link.word_address = st_reg.addr;
  assign link.chip_select_hi = st_reg.cs;
  assign link.chip_select_lo_n = ~st_reg.cs;
  assign link.sync_write_n = st_reg.sw_n;
  assign link.low_byte_strobe_n = st_reg.strobe_n[LOW_LANE];
  assign link.high_byte_strobe_n = st_reg.strobe_n[HIGH_LANE];
  assign link.out_en_n = st_reg.oe_n;
  assign link.data_in_latch_ctl = st_reg.dl;
  assign link.ctl_dq = st_reg.dq;
  assign link.ctl_dq_oe = st_reg.dq_oe;

endmodule // ssbwl_ctrl
`default_nettype wire

// ### dv/ssbwl_link_chk.sv
// link checker: assertions on the shared memory pins
`timescale 1ns/1ps
`default_nettype none
module ssbwl_link_chk
  import ssbwl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic chip_select_hi,
  input wire logic chip_select_lo_n,
  input wire logic sync_write_n,
  input wire logic low_byte_strobe_n,
  input wire logic high_byte_strobe_n,
  input wire logic out_en_n,
  input wire logic data_in_latch_ctl,
  input wire logic [DATA_W-1:0] ctl_dq,
  input wire logic ctl_dq_oe,
  input wire logic [DATA_W-1:0] dev_dq,
  input wire logic dev_dq_oe,
  input wire logic [DATA_W-1:0] data_bus
);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic rd_c;
  logic wr_c;
  // cycle kinds as the device registers them
  assign rd_c = chip_select_hi & ~chip_select_lo_n & sync_write_n;
  assign wr_c = chip_select_hi & ~chip_select_lo_n & ~sync_write_n;
  // controller owns the bus and the bus carries its word
  logic ctl_on_bus;
  assign ctl_on_bus = ctl_dq_oe & (data_bus == ctl_dq);
  a_oe_gates_drive:
    assert property (out_en_n |-> !dev_dq_oe) else $error("drive, oe high");
  a_drive_needs_read:
    assert property ($rose(dev_dq_oe) |-> $past(rd_c, 2))
    else $error("drive began without a read");
  a_write_frees_bus:
    assert property (wr_c |-> ##2 !dev_dq_oe) else $error("bus kept on write");
  a_deselect_quiet:
    assert property (!chip_select_hi |-> ##2 !dev_dq_oe)
    else $error("drive after deselect");
  a_read_word_held:
    assert property (!rd_c |-> ##2 $stable(dev_dq))
    else $error("read word changed without read");
  a_latch_data_first:
    assert property ($fell(data_in_latch_ctl) |-> $past(ctl_on_bus))
    else $error("latch closed before data");
  a_strobe_after_write:
    assert property (!(low_byte_strobe_n && high_byte_strobe_n) |->
                     $past(wr_c))
    else $error("strobe without write");
  a_strobe_pulse:
    assert property (!low_byte_strobe_n |=> low_byte_strobe_n)
    else $error("strobe held over");
  a_no_contention:
    assert property (!(dev_dq_oe && ctl_dq_oe)) else $error("both drive");
  a_transparent_data:
    assert property (!low_byte_strobe_n && data_in_latch_ctl |-> ctl_dq_oe)
    else $error("transparent write, no data");
  // main scenarios reached
  cover property (wr_c ##1 !low_byte_strobe_n && !data_in_latch_ctl);
  cover property (rd_c && word_address == '1);
  cover property (wr_c ##1 !high_byte_strobe_n && data_in_latch_ctl);
  cover property ($rose(dev_dq_oe));
endmodule // ssbwl_link_chk
`default_nettype wire

// ### dv/test_sync_sram_byte_write_latch.sv
// self-checking bench: controller and device joined on one link
`timescale 1ns/1ps
`default_nettype none
module test_sync_sram_byte_write_latch;
  import ssbwl_pkg::*;
  logic clk_sys_i, srst_i, req_valid_i, req_write_i, req_latched_i;
  logic [ADDR_W-1:0] req_addr_i;
  logic [DATA_W-1:0] req_wdata_i;
  logic [LANES-1:0] req_be_i;
  logic req_ready_o, rsp_valid_o, busy_reading_o, busy_seen;
  logic [DATA_W-1:0] rsp_rdata_o, got;
  logic [ADDR_W-1:0] a;
  int error_cnt, tests_run, cyc;
  ssbwl_link_if lnk ();
  ssbwl_device ssbwl_device_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .link(lnk), .busy_reading_o(busy_reading_o));
  ssbwl_ctrl ssbwl_ctrl_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_latched_i(req_latched_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .link(lnk));
  ssbwl_link_chk ssbwl_link_chk_inst (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .word_address(lnk.word_address),
    .chip_select_hi(lnk.chip_select_hi),
    .chip_select_lo_n(lnk.chip_select_lo_n),
    .sync_write_n(lnk.sync_write_n),
    .low_byte_strobe_n(lnk.low_byte_strobe_n),
    .high_byte_strobe_n(lnk.high_byte_strobe_n),
    .out_en_n(lnk.out_en_n), .data_in_latch_ctl(lnk.data_in_latch_ctl),
    .ctl_dq(lnk.ctl_dq), .ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq(lnk.dev_dq),
    .dev_dq_oe(lnk.dev_dq_oe), .data_bus(lnk.data_bus));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one request; valid for one cycle, other inputs stay put until ready returns, as the port needs
  task automatic xfer(input logic w, input logic l,
                      input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] d, input logic [LANES-1:0] be);
    logic seen;
    seen = 1'b0;
    busy_seen = 1'b0;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_latched_i <= l;
    req_addr_i <= ad;
    req_wdata_i <= d;
    req_be_i <= be;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk_sys_i);
      #1;
      if (busy_reading_o === 1'b1) busy_seen = 1'b1;
      if (rsp_valid_o === 1'b1) begin
        seen = 1'b1;
        got = rsp_rdata_o;
      end
      if (req_ready_o === 1'b1 && (w || seen)) break;
    end
  endtask
  // clock and hang guard; the run needs about 140 cycles
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {req_valid_i, req_write_i, req_latched_i} = 3'h0;
    req_addr_i = 14'h0000;
    req_wdata_i = 16'h0000;
    req_be_i = 2'h0;
    srst_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1 chk({14'h0000, lnk.dev_dq_oe, busy_reading_o}, 16'h0000);
    xfer(1'b1, 1'b0, 14'h0000, 16'h0f1e, 2'h3);
    xfer(1'b1, 1'b1, 14'h3fff, 16'hc3a5, 2'h3);
    xfer(1'b0, 1'b0, 14'h0000, 16'h0000, 2'h0);
    chk(got, 16'h0f1e);
    chk({15'h0000, busy_seen}, 16'h0001);
    xfer(1'b0, 1'b0, 14'h3fff, 16'h0000, 2'h0);
    chk(got, 16'hc3a5);
    $display("test boundary words done");
    // every lane mask in both write modes, over a known old word
    for (int l = 0; l < 2; l++) begin
      for (int b = 0; b < 4; b++) begin
        a = 14'(16 + l * 4 + b);
        xfer(1'b1, 1'b0, a, 16'h1234, 2'h3);
        xfer(1'b1, l[0], a, 16'hedcb, b[1:0]);
        chk({15'h0000, busy_seen}, 16'h0000);
        xfer(1'b0, 1'b0, a, 16'h0000, 2'h0);
        chk(got, {b[1] ? 8'hed : 8'h12, b[0] ? 8'hcb : 8'h34});
      end
    end
    $display("test lane masks done");
    // reset mid-run: pins float, array keeps its words
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1 chk({14'h0000, lnk.dev_dq_oe, busy_reading_o}, 16'h0000);
    xfer(1'b0, 1'b0, 14'h3fff, 16'h0000, 2'h0);
    chk(got, 16'hc3a5);
    $display("test reset in run done");
    conclude();
  end
endmodule // test_sync_sram_byte_write_latch
`default_nettype wire
